// File: core/aisr_consts.vh
// register offsets, field positions, reset values and encodings for the accelerometer register bank
// assumes a byte-wide register port addressed by 8-bit offsets
`ifndef AISR_CONSTS_VH
`define AISR_CONSTS_VH
`define AISR_ADDR_STATUS 8'h14
`define AISR_ADDR_RANGE 8'h20
`define AISR_ADDR_X_AXIS_OFFSET_VALUE_LO 8'h21
`define AISR_ADDR_X_AXIS_OFFSET_VALUE_HI 8'h22
`define AISR_ADDR_X_AXIS_GAIN_VALUE_LO 8'h27
`define AISR_RANGE_RESET 8'h00
`define AISR_STATUS_RESET 8'h00
`define AISR_INTEN_SHAKE 3
`define AISR_INTEN_TILT35 4
`define AISR_INTEN_ACQ 7
`define AISR_MOT_ANYM 2
`define AISR_MOT_SHAKE 3
`define AISR_MOT_TILT35 4
`define AISR_ST_SHAKE 3
`define AISR_ST_TILT35 4
`define AISR_ST_FIFO 5
`define AISR_ST_ACQ 7
`define AISR_RNG_MSB 6
`define AISR_RNG_LSB 4
`define AISR_OUTPUT_FILTER_ENABLE_BIT 3
`define AISR_RNG_2G 3'h0
`define AISR_RNG_4G 3'h1
`define AISR_RNG_8G 3'h2
`define AISR_RNG_16G 3'h3
`define AISR_RNG_12G 3'h4
`define AISR_BW_1 3'h1
`define AISR_BW_2 3'h2
`define AISR_BW_3 3'h3
`define AISR_BW_5 3'h5
`endif

// File: core/aisr_regs.v
// register bank: interrupt status, range/filter control, x offset with gain msb, offset path
// assumes reg_* port is synchronous to clk_sys; event strobes come from logic on the same clock
//
// What this block does, and what software must do (R10, R14, R15)
// R1 - shake flag needs int, shake, anymotion enables
// R2 - tilt35 flag needs int, tilt35, anymotion enables
// R3 - status bit one means pending
// R4 - fifo flag is OR of three flags
// R5 - acquire flag only awake and enabled
// R6 - outputs saturated two's complement results
// R7 - range field decodes 2,4,8,16,12 g
// R8 - bit 3 enables output low-pass filter
// R9 - bandwidth codes 1,2,3,5 valid, others reserved
// R10 - software writes zero to range bit 7
// R11 - signed offset added to x filter output
// R12 - high byte holds offset msbs, gain bit 8
// R13 - offset and gain loaded from otp
// R14 - software uses read-modify-write on shared bytes
// R15 - software avoids reserved range and bandwidth codes
`timescale 1ns/1ps
`include "aisr_consts.vh"

module aisr_regs (
   input wire clk_sys,
   input wire reset_n,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   input wire [7:0] int_enable,
   input wire [7:0] motion_control,
   input wire wake_state,
   input wire shake_event,
   input wire tilt35_event,
   input wire sample_event,
   input wire queue_full_flag,
   input wire queue_threshold_flag,
   input wire queue_empty_flag,
   input wire otp_load,
   input wire [14:0] otp_x_offset,
   input wire [8:0] otp_x_gain,
   input wire filt_valid,
   input wire signed [15:0] x_filter_out,
   output reg [15:0] x_axis_result,
   output reg x_result_valid,
   output reg [2:0] range_select,
   output reg range_reserved,
   output reg output_filter_enable,
   output reg [2:0] filter_bandwidth_select,
   output reg bandwidth_reserved,
   output reg [14:0] x_axis_offset_value,
   output reg [8:0] x_axis_gain_value
);

   // ********************************
   // status flags
   // ********************************
   reg [7:0] status;
   reg [7:0] range_scale_control;
   reg [7:0] next_status;
   wire st_wr = reg_wr && (reg_addr == `AISR_ADDR_STATUS);
   wire shake_ok = int_enable[`AISR_INTEN_SHAKE] && motion_control[`AISR_MOT_SHAKE]
                   && motion_control[`AISR_MOT_ANYM]; // see R1
   wire tilt_ok = int_enable[`AISR_INTEN_TILT35] && motion_control[`AISR_MOT_TILT35]
                  && motion_control[`AISR_MOT_ANYM]; // see R2
   wire acq_ok = wake_state && int_enable[`AISR_INTEN_ACQ]; // see R5
   wire shake_set = shake_ok && shake_event;
   wire tilt_set = tilt_ok && tilt35_event;
   wire acq_set = acq_ok && sample_event;

   // software clears a flag by writing zero; a same-cycle event wins over the clear
   always @* begin
      next_status = st_wr ? (status & reg_wdata) : status;
      if (shake_set) begin
         next_status[`AISR_ST_SHAKE] = 1'b1; // see R1
      end
      if (tilt_set) begin
         next_status[`AISR_ST_TILT35] = 1'b1; // see R2
      end
      if (acq_set) begin
         next_status[`AISR_ST_ACQ] = 1'b1; // see R5
      end
      // combined queue flag follows its sources, not sticky
      next_status[`AISR_ST_FIFO] = queue_full_flag | queue_threshold_flag | queue_empty_flag; // see R4
      next_status[6] = 1'b0;
      next_status[2:0] = 3'h0;
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         status <= `AISR_STATUS_RESET;
      end else begin
         status <= next_status; // see R3
      end
   end

   // ********************************
   // range and offset registers
   // ********************************
   wire [7:0] x_axis_offset_value_hi = {x_axis_gain_value[8], x_axis_offset_value[14:8]};

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         range_scale_control <= `AISR_RANGE_RESET;
         x_axis_offset_value <= 15'h0000;
         x_axis_gain_value <= 9'h000;
      end else if (otp_load) begin
         // trimmed values come back whenever the loader fires after power-up
         x_axis_offset_value <= otp_x_offset; // see R13
         x_axis_gain_value <= otp_x_gain; // see R13
      end else if (reg_wr) begin
         case (reg_addr)
            `AISR_ADDR_RANGE: begin
               // bit 7 kept zero whatever software sends
               range_scale_control <= {1'b0, reg_wdata[6:0]}; // see R10
            end
            `AISR_ADDR_X_AXIS_OFFSET_VALUE_LO: begin
               x_axis_offset_value[7:0] <= reg_wdata; // see R12
            end
            `AISR_ADDR_X_AXIS_OFFSET_VALUE_HI: begin
               x_axis_offset_value[14:8] <= reg_wdata[6:0]; // see R12
               x_axis_gain_value[8] <= reg_wdata[7]; // see R12
            end
            `AISR_ADDR_X_AXIS_GAIN_VALUE_LO: begin
               x_axis_gain_value[7:0] <= reg_wdata;
            end
            default: begin
               x_axis_gain_value <= x_axis_gain_value;
            end
         endcase
      end
   end

   // ********************************
   // decoded controls
   // ********************************
   wire [2:0] rng = range_scale_control[`AISR_RNG_MSB:`AISR_RNG_LSB];
   wire [2:0] bw = range_scale_control[2:0];
   reg rng_bad;
   reg bw_bad;
   // reserved codes are not remapped; they pass through and raise a flag instead
   always @* begin
      case (rng) // see R7
         `AISR_RNG_2G: rng_bad = 1'b0;
         `AISR_RNG_4G: rng_bad = 1'b0;
         `AISR_RNG_8G: rng_bad = 1'b0;
         `AISR_RNG_16G: rng_bad = 1'b0;
         `AISR_RNG_12G: rng_bad = 1'b0;
         default: rng_bad = 1'b1;
      endcase
   end

   always @* begin
      case (bw) // see R9
         `AISR_BW_1: bw_bad = 1'b0;
         `AISR_BW_2: bw_bad = 1'b0;
         `AISR_BW_3: bw_bad = 1'b0;
         `AISR_BW_5: bw_bad = 1'b0;
         default: bw_bad = 1'b1;
      endcase
   end

   // ********************************
   // offset path and read port
   // ********************************
   // the 15-bit offset is sign-extended then added; sum saturates rather than wraps
   wire signed [16:0] x_sum = {x_filter_out[15], x_filter_out}
                              + {{2{x_axis_offset_value[14]}}, x_axis_offset_value}; // see R11
   reg [15:0] x_sat;
   always @* begin
      if (x_sum[16:15] == 2'b01) begin
         x_sat = 16'h7fff; // see R6
      end else if (x_sum[16:15] == 2'b10) begin
         x_sat = 16'h8000; // see R6
      end else begin
         x_sat = x_sum[15:0]; // see R6
      end
   end

   // ********************************
   // read multiplexer
   // ********************************
   reg [7:0] next_rdata;
   // read data holds between strobes so a slow host may sample it late
   always @* begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            `AISR_ADDR_STATUS: next_rdata = status; // see R3
            `AISR_ADDR_RANGE: next_rdata = range_scale_control;
            `AISR_ADDR_X_AXIS_OFFSET_VALUE_LO: next_rdata = x_axis_offset_value[7:0];
            `AISR_ADDR_X_AXIS_OFFSET_VALUE_HI: next_rdata = x_axis_offset_value_hi; // see R12
            `AISR_ADDR_X_AXIS_GAIN_VALUE_LO: next_rdata = x_axis_gain_value[7:0];
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
         x_axis_result <= 16'h0000;
         x_result_valid <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         x_result_valid <= filt_valid;
         if (filt_valid) begin
            x_axis_result <= x_sat; // see R11
         end
      end
   end

   // ********************************
   // decoded control outputs
   // ********************************
   // one register stage keeps every output straight from a flop, at one cycle of latency
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         range_select <= 3'h0;
         range_reserved <= 1'b0;
         output_filter_enable <= 1'b0;
         filter_bandwidth_select <= 3'h0;
         bandwidth_reserved <= 1'b0;
      end else begin
         range_select <= rng; // see R7
         range_reserved <= rng_bad;
         output_filter_enable <= range_scale_control[`AISR_OUTPUT_FILTER_ENABLE_BIT]; // see R8
         filter_bandwidth_select <= bw; // see R9
         bandwidth_reserved <= bw_bad;
      end
   end

endmodule // aisr_regs

// File: tb/aisr_chk_assertions.sv
// port assertions for the register bank
// assumes one clock and an async active-low reset
`timescale 1ns/1ps
// ********
// checker
// ********
module aisr_chk (
   input wire clk_sys, reset_n, reg_wr, reg_rd, shake_event, otp_load, filt_valid, x_result_valid,
   input wire output_filter_enable,
   input wire [7:0] reg_addr, reg_wdata, reg_rdata, int_enable, motion_control,
   input wire [2:0] range_select, filter_bandwidth_select,
   input wire [14:0] otp_x_offset, x_axis_offset_value,
   input wire [8:0] otp_x_gain, x_axis_gain_value,
   input wire signed [15:0] x_filter_out,
   input wire [15:0] x_axis_result
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   sequence s_rng_wr;
      reg_wr && !otp_load && reg_addr == 8'h20;
   endsequence
   sequence s_shake_read;
      shake_event && int_enable[3] && motion_control[3] && motion_control[2]
      ##1 reg_rd && !reg_wr && reg_addr == 8'h14;
   endsequence
   a_range_decode: assert property (s_rng_wr |=> ##1
      {range_select, output_filter_enable, filter_bandwidth_select} == $past(reg_wdata[6:0], 2)) else $error("decode");
   a_range_bit7: assert property (reg_rd && reg_addr == 8'h20 |=> !reg_rdata[7]) else $error("bit 7");
   a_unmapped_read: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00) else $error("unmapped");
   a_shake_flag: assert property (s_shake_read |=> reg_rdata[3]) else $error("shake flag");
   a_otp_load: assert property (otp_load |=> x_axis_offset_value == $past(otp_x_offset) &&
      x_axis_gain_value == $past(otp_x_gain)) else $error("otp load");
   a_result_valid: assert property (filt_valid |=> x_result_valid) else $error("valid");
   a_valid_drop: assert property (!filt_valid |=> !x_result_valid) else $error("valid drop");
   // small positive inputs only, so saturation cannot hide a wrong sum
   a_offset_sum: assert property (filt_valid && x_filter_out[15:14] == 2'b00 |=>
      x_axis_result == $past(x_filter_out) + {$past(x_axis_offset_value[14]), $past(x_axis_offset_value)})
      else $error("sum");
endmodule // aisr_chk
bind aisr_regs aisr_chk u_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .shake_event(shake_event),
   .otp_load(otp_load), .filt_valid(filt_valid), .x_result_valid(x_result_valid),
   .output_filter_enable(output_filter_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .int_enable(int_enable), .motion_control(motion_control), .range_select(range_select),
   .filter_bandwidth_select(filter_bandwidth_select), .otp_x_offset(otp_x_offset),
   .x_axis_offset_value(x_axis_offset_value), .otp_x_gain(otp_x_gain), .x_axis_gain_value(x_axis_gain_value),
   .x_filter_out(x_filter_out), .x_axis_result(x_axis_result));

// File: tb/aisr_host.sv
// host model: byte accesses to the register bank
// assumes each call starts just after a rising edge
`timescale 1ns/1ps
// ********
// host
// ********
module aisr_host (
   input wire clk_sys,
   input wire [7:0] reg_rdata,
   output logic reg_wr, reg_rd,
   output logic [7:0] reg_addr, reg_wdata
);
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
   task acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      @(posedge clk_sys) #1;
      q = reg_rdata;
      // released lines show no stale value
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
      @(posedge clk_sys) #1;
   endtask
   task rmw(input logic [7:0] a, m, v);
      logic [7:0] q;
      acc(1'b0, a, 8'h00, q);
      acc(1'b1, a, (q & ~m) | (v & m), q);
   endtask
endmodule // aisr_host

// File: tb/testbench.sv
// bench for the register bank with the host model
// assumes 50 MHz clock and the header offsets
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("FAIL %0t %h %h", $time, a, b); end end
// ********
// bench
// ********
module testbench;
   logic clk_sys = 0, reset_n = 0, wake_state = 0, shake_event = 0, tilt35_event = 0, sample_event = 0, otp_load = 0;
   logic queue_full_flag = 0, queue_threshold_flag = 0, queue_empty_flag = 0, filt_valid = 0, reg_wr, reg_rd;
   logic x_result_valid, range_reserved, output_filter_enable, bandwidth_reserved;
   logic [7:0] int_enable = 8'h00, motion_control = 8'h00, reg_addr, reg_wdata, reg_rdata, q;
   logic [14:0] otp_x_offset = 15'h0000, x_axis_offset_value;
   logic [8:0] otp_x_gain = 9'h000, x_axis_gain_value;
   logic signed [15:0] x_filter_out = 16'sh0000;
   logic [15:0] x_axis_result;
   logic [2:0] range_select, filter_bandwidth_select;
   int fail_count = 0, check_count = 0;
   aisr_regs dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_enable(int_enable), .motion_control(motion_control),
      .wake_state(wake_state), .shake_event(shake_event), .tilt35_event(tilt35_event), .sample_event(sample_event),
      .queue_full_flag(queue_full_flag), .queue_threshold_flag(queue_threshold_flag),
      .queue_empty_flag(queue_empty_flag), .otp_load(otp_load), .otp_x_offset(otp_x_offset),
      .otp_x_gain(otp_x_gain), .filt_valid(filt_valid), .x_filter_out(x_filter_out), .x_axis_result(x_axis_result),
      .x_result_valid(x_result_valid), .range_select(range_select), .range_reserved(range_reserved),
      .output_filter_enable(output_filter_enable), .filter_bandwidth_select(filter_bandwidth_select),
      .bandwidth_reserved(bandwidth_reserved), .x_axis_offset_value(x_axis_offset_value),
      .x_axis_gain_value(x_axis_gain_value));
   aisr_host u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   task tally_and_finish;
      if (fail_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task t_range;
      logic [2:0] bw;
      u_host.acc(1'b0, 8'h30, 8'h00, q);
      `CHK(q, 8'h00)
      for (int i = 0; i < 5; i++) begin
         bw = (i == 3) ? 3'h5 : 3'(i % 3 + 1);
         u_host.acc(1'b1, 8'h20, {1'b0, 3'(i), i[0], bw}, q);
         u_host.acc(1'b0, 8'h20, 8'h00, q);
         `CHK({q, range_reserved, bandwidth_reserved}, {1'b0, 3'(i), i[0], bw, 2'b00})
         `CHK({range_select, output_filter_enable, filter_bandwidth_select}, {3'(i), i[0], bw})
      end
   endtask
   task t_flags;
      int_enable = 8'h98;
      for (int k = 3; k < 5; k++) begin
         for (int m = 0; m < 2; m++) begin
            motion_control = {3'h0, 2'b11, m[0], 2'h0};
            {tilt35_event, shake_event} = 2'(k - 2);
            @(posedge clk_sys) #1;
            {tilt35_event, shake_event} = 2'b00;
            u_host.acc(1'b0, 8'h14, 8'h00, q);
            `CHK(q[k], m[0])
            u_host.acc(1'b1, 8'h14, 8'h00, q);
         end
      end
      // the combined flag is registered, so give it one edge before the read
      for (int j = 0; j < 3; j++) begin
         {queue_full_flag, queue_threshold_flag, queue_empty_flag} = 3'(1 << j);
         @(posedge clk_sys) #1;
         u_host.acc(1'b0, 8'h14, 8'h00, q);
         `CHK(q[5], 1'b1)
      end
      {queue_full_flag, queue_threshold_flag, queue_empty_flag} = 3'h0;
      for (int m = 0; m < 4; m++) begin
         {int_enable[7], wake_state} = 2'(m);
         sample_event = 1;
         @(posedge clk_sys) #1;
         sample_event = 0;
         u_host.acc(1'b0, 8'h14, 8'h00, q);
         `CHK({q[7], q[5]}, {m == 3, 1'b0})
      end
   endtask
   task t_offset;
      {otp_x_offset, otp_x_gain, otp_load} = {15'h7ff0, 9'h1a5, 1'b1};
      @(posedge clk_sys) #1;
      otp_load = 0;
      u_host.rmw(8'h22, 8'h80, 8'h00);
      u_host.acc(1'b0, 8'h22, 8'h00, q);
      `CHK({q, x_axis_gain_value}, {8'h7f, 9'h0a5})
      `CHK(x_axis_offset_value, 15'h7ff0)
      u_host.acc(1'b0, 8'h27, 8'h00, q);
      `CHK(q, 8'ha5)
      {x_filter_out, filt_valid} = {16'sh0100, 1'b1};
      @(posedge clk_sys) #1;
      filt_valid = 0;
      `CHK({x_result_valid, x_axis_result}, {1'b1, 16'h00f0})
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 reset_n = 1;
      t_range;
      t_flags;
      t_offset;
      tally_and_finish;
   end
   // about 26 times the expected run
   initial begin
      #40000;
      fail_count++;
      tally_and_finish;
   end
endmodule // testbench
